// [rtl/flc_consts.svh]
// named constants of the line coder: timing, scrambler, code groups
// assumes inclusion by every design file that needs a figure
`ifndef FLC_CONSTS_SVH
`define FLC_CONSTS_SVH
`define FLC_CLK_PERIOD_NS 40
`define FLC_LINK_PERIOD_NS 320
`define FLC_LINE_RATE_MHZ 125
`define FLC_BIT_CYC (`FLC_LINK_PERIOD_NS / `FLC_CLK_PERIOD_NS)
`define FLC_PH_W 4
`define FLC_BIT_LAST `FLC_PH_W'(`FLC_BIT_CYC - 1)
`define FLC_BIT_MID `FLC_PH_W'(`FLC_BIT_CYC / 2)
`define FLC_LFSR_W 11
`define FLC_LFSR_PERIOD 11'h7FF
`define FLC_TAP_HI 10
`define FLC_TAP_LO 8
`define FLC_LFSR_SEED 11'h7FF
`define FLC_LOCK_W 5
`define FLC_LOCK_CNT 5'h1E
`define FLC_GRP_LAST 3'h4
`define FLC_GRP_MSB 4
`define FLC_CG_I 5'h1F
`define FLC_CG_J 5'h18
`define FLC_CG_K 5'h11
`define FLC_CG_T 5'h0D
`define FLC_CG_R 5'h07
`define FLC_CG_H 5'h04
`define FLC_JK 10'h311
`define FLC_PRE_NIB 4'h5
`define FLC_MLT_POS 2'h1
`define FLC_MLT_NEG 2'h3
`endif

// [rtl/flc_pkg.sv]
// types and code-group table of the line coder
// assumes nothing beyond the constants header
package flc_pkg;
   typedef enum logic [1:0] {tx_idle = 2'b00, tx_k = 2'b01, tx_data = 2'b10,
      tx_r = 2'b11} flc_tx_e;
   typedef enum logic [0:0] {rx_idle = 1'b0, rx_frame = 1'b1} flc_rx_e;
   typedef logic [4:0] flc_grp_t;

   // five-bit data code group for a nibble
   function automatic flc_grp_t flc_enc(input logic [3:0] n);
      case (n)
         4'h0: flc_enc = 5'h1E;
         4'h1: flc_enc = 5'h09;
         4'h2: flc_enc = 5'h14;
         4'h3: flc_enc = 5'h15;
         4'h4: flc_enc = 5'h0A;
         4'h5: flc_enc = 5'h0B;
         4'h6: flc_enc = 5'h0E;
         4'h7: flc_enc = 5'h0F;
         4'h8: flc_enc = 5'h12;
         4'h9: flc_enc = 5'h13;
         4'hA: flc_enc = 5'h16;
         4'hB: flc_enc = 5'h17;
         4'hC: flc_enc = 5'h1A;
         4'hD: flc_enc = 5'h1B;
         4'hE: flc_enc = 5'h1C;
         default: flc_enc = 5'h1D;
      endcase
   endfunction

   // {valid, nibble} for a received group, reverse search of the table
   function automatic logic [4:0] flc_dec(input flc_grp_t g);
      flc_dec = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (flc_enc(4'(i)) == g) begin
            flc_dec = {1'b1, 4'(i)};
         end
      end
   endfunction
endpackage

// [rtl/flc_scr_if.sv]
// carrier between the coder core and one scrambler instance
// assumes core drives the bit stream and scrambler answers
`timescale 1ns/1ps
interface flc_scr_if;
   logic bit_en;
   logic din;
   logic dout;
   logic bypass;
   logic sync;
   logic resync;
   logic locked;
   modport core(output bit_en, din, bypass, sync, resync, input dout, locked);
   modport scr(input bit_en, din, bypass, sync, resync, output dout, locked);
endinterface

// [rtl/flc_scrambler.sv]
// 11-bit lfsr scrambler, or self-synchronising descrambler when sync is set
// assumes one bit_en pulse per line bit, idle stream of ones before lock
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_scrambler (
   input wire logic clk_in,
   input wire logic rst_n_in,
   flc_scr_if.scr s
);
   logic [`FLC_LFSR_W-1:0] lfsr, next_lfsr;
   logic [`FLC_LOCK_W-1:0] lock_cnt, next_lock_cnt;
   logic lock, next_lock;
   logic key;
   logic [`FLC_LFSR_W-1:0] per_cnt;

   // key bit from taps of x^11 + x^9 + 1
   assign key = lfsr[`FLC_TAP_HI] ^ lfsr[`FLC_TAP_LO];
   assign s.dout = s.bypass ? s.din : (s.din ^ key);
   assign s.locked = s.bypass | lock;

   // lfsr advance, idle loading and lock search
   always_comb begin
      next_lfsr = lfsr;
      next_lock_cnt = lock_cnt;
      next_lock = lock;
      if (s.resync) begin
         next_lock = 1'b0;
         next_lock_cnt = '0;
      end
      if (s.bit_en) begin
         if (s.sync && !lock && !s.bypass) begin // plain ones would zero it
            next_lfsr = {lfsr[`FLC_LFSR_W-2:0], ~s.din};
            if (~s.din == key) begin
               if (lock_cnt == `FLC_LOCK_CNT) begin
                  next_lock = 1'b1;
               end else begin
                  next_lock_cnt = lock_cnt + 1'b1;
               end
            end else begin
               next_lock_cnt = '0;
            end
         end else begin
            next_lfsr = {lfsr[`FLC_LFSR_W-2:0], key};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lfsr <= `FLC_LFSR_SEED;
         lock_cnt <= '0;
         lock <= 1'b0;
      end else begin
         lfsr <= next_lfsr;
         lock_cnt <= next_lock_cnt;
         lock <= next_lock;
      end
   end

   // helper: bit count modulo the sequence length
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         per_cnt <= '0;
      end else if (s.bit_en) begin
         per_cnt <= (per_cnt == `FLC_LFSR_PERIOD - 1'b1) ? '0 : per_cnt + 1'b1;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   lfsr_live_a:
   assert property (lfsr != '0) else $error("lfsr reached all zeros");
   lfsr_shift_a:
   assert property (s.bit_en |=> lfsr[`FLC_LFSR_W-1:1] == $past(lfsr[`FLC_LFSR_W-2:0]))
      else $error("lfsr did not shift");
   lfsr_period_a:
   assert property (!s.sync && $rose(per_cnt == '0) |-> lfsr == `FLC_LFSR_SEED)
      else $error("scrambler sequence not 2047 long");
endmodule

// [rtl/flc_cdr.sv]
// clock and data recovery from the edges of the nrzi level
// assumes nrzi_in already synchronised to clk_in
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_cdr (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic nrzi_in,
   output logic bit_stb_out,
   output logic nrz_out
);
   logic prev, next_prev;
   logic [`FLC_PH_W-1:0] ph, next_ph;
   logic lvl, next_lvl;
   logic next_stb, next_nrz;

   // phase snaps to each edge; sample mid-bit, transition means one
   always_comb begin
      next_prev = nrzi_in;
      if (nrzi_in != prev || ph == `FLC_BIT_LAST) begin
         next_ph = '0;
      end else begin
         next_ph = ph + 1'b1;
      end
      next_stb = (ph == `FLC_BIT_MID);
      next_lvl = next_stb ? nrzi_in : lvl;
      next_nrz = next_stb ? (nrzi_in ^ lvl) : nrz_out;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev <= 1'b0;
         ph <= '0;
         lvl <= 1'b0;
         bit_stb_out <= 1'b0;
         nrz_out <= 1'b0;
      end else begin
         prev <= next_prev;
         ph <= next_ph;
         lvl <= next_lvl;
         bit_stb_out <= next_stb;
         nrz_out <= next_nrz;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   stb_gap_a:
   assert property (bit_stb_out |=> !bit_stb_out [*3]) else $error("bit strobes too close");
   nrz_conv_a:
   assert property (bit_stb_out |-> nrz_out == (lvl != $past(lvl)))
      else $error("nrzi to nrz conversion wrong");
endmodule

// [rtl/flc_line_coder.sv]
// 100 Mbit line coding path between an MII MAC and the line driver/receiver
// assumes MAC on clk_in; line bit clock and rx symbols come from outside
// Function
// - tx order: code, serialise, scramble, nrzi, mlt3
// - MII nibbles become serial line bit stream
// - code groups first, then scrambled
// - scrambled bits go nrzi, then three-level
// - rx order reverses tx path fully
// - bit timing recovered from nrzi edges
// - recovered timing converts nrzi to nrz
// - descramble before decoding code groups
// - decoded nibbles delivered to MAC
// - scrambler is 11-bit lfsr
// - sequence repeats after 2047 bits
// - descrambler uses transmitter's sequence
// - scrambling bypassed outside 100 Mbit mode
`timescale 1ns/1ps
`include "flc_consts.svh"
module flc_line_coder (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic speed_100_in,
   input wire logic tx_bit_clk_in,
   input wire logic tx_en_in,
   input wire logic tx_er_in,
   input wire logic [3:0] txd_in,
   output logic tx_take_out,
   output logic mlt3_pos_out,
   output logic mlt3_neg_out,
   input wire logic rx_pos_in,
   input wire logic rx_neg_in,
   output logic rx_stb_out,
   output logic rx_dv_out,
   output logic rx_er_out,
   output logic [3:0] rxd_out,
   output logic rx_lock_out
);
   flc_scr_if tx_scr();
   flc_scr_if rx_scr();

   logic [2:0] tck;
   logic [1:0] pos_s, neg_s;
   logic tx_bit;
   logic cdr_stb, cdr_nrz;

   // two-flop synchronisers for link clock and line symbols
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tck <= 3'h0;
         pos_s <= 2'h0;
         neg_s <= 2'h0;
      end else begin
         tck <= {tck[1:0], tx_bit_clk_in};
         pos_s <= {pos_s[0], rx_pos_in};
         neg_s <= {neg_s[0], rx_neg_in};
      end
   end
   assign tx_bit = tck[1] & ~tck[2];

   // ---------------- transmit ----------------
   flc_pkg::flc_tx_e tx_st, next_tx_st, grp_st;
   logic [2:0] tx_bitn, next_tx_bitn;
   flc_pkg::flc_grp_t tx_sh, next_tx_sh, grp;
   logic tx_nrzi, next_tx_nrzi;
   logic [1:0] mlt, next_mlt;
   logic next_pos, next_neg;
   logic take, boundary;

   // scrambler hook-up: plain code bits in, scrambled bits out
   assign tx_scr.bit_en = tx_bit;
   assign tx_scr.din = tx_sh[`FLC_GRP_MSB];
   assign tx_scr.bypass = ~speed_100_in;
   assign tx_scr.sync = 1'b0;
   assign tx_scr.resync = 1'b0;

   flc_scrambler u_tx_scr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .s(tx_scr.scr)
   );

   // next code group chosen at each group boundary
   always_comb begin
      grp = `FLC_CG_I;
      grp_st = tx_st;
      take = 1'b0;
      case (tx_st)
         flc_pkg::tx_idle: begin
            if (tx_en_in) begin
               grp = `FLC_CG_J;
               grp_st = flc_pkg::tx_k;
               take = 1'b1;
            end
         end
         flc_pkg::tx_k: begin
            grp = `FLC_CG_K;
            grp_st = flc_pkg::tx_data;
            take = 1'b1;
         end
         flc_pkg::tx_data: begin
            if (tx_en_in) begin
               grp = tx_er_in ? `FLC_CG_H : flc_pkg::flc_enc(txd_in);
               take = 1'b1;
            end else begin
               grp = `FLC_CG_T;
               grp_st = flc_pkg::tx_r;
            end
         end
         flc_pkg::tx_r: begin
            grp = `FLC_CG_R;
            grp_st = flc_pkg::tx_idle;
         end
         default: begin
            grp = `FLC_CG_I;
            grp_st = flc_pkg::tx_idle;
         end
      endcase
   end

   assign boundary = tx_bit && (tx_bitn == `FLC_GRP_LAST);
   assign tx_take_out = boundary & take;

   // serialiser, nrzi and mlt3 steps per line bit
   always_comb begin
      next_tx_st = tx_st;
      next_tx_bitn = tx_bitn;
      next_tx_sh = tx_sh;
      next_tx_nrzi = tx_nrzi;
      next_mlt = mlt;
      if (tx_bit) begin
         next_tx_nrzi = tx_nrzi ^ tx_scr.dout;
         if (next_tx_nrzi != tx_nrzi) begin
            next_mlt = mlt + 1'b1;
         end
         if (boundary) begin
            next_tx_sh = grp;
            next_tx_bitn = 3'h0;
            next_tx_st = grp_st;
         end else begin
            next_tx_sh = {tx_sh[`FLC_GRP_MSB-1:0], 1'b0};
            next_tx_bitn = tx_bitn + 1'b1;
         end
      end
      next_pos = (next_mlt == `FLC_MLT_POS);
      next_neg = (next_mlt == `FLC_MLT_NEG);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_st <= flc_pkg::tx_idle;
         tx_bitn <= 3'h0;
         tx_sh <= `FLC_CG_I;
         tx_nrzi <= 1'b0;
         mlt <= 2'h0;
         mlt3_pos_out <= 1'b0;
         mlt3_neg_out <= 1'b0;
      end else begin
         tx_st <= next_tx_st;
         tx_bitn <= next_tx_bitn;
         tx_sh <= next_tx_sh;
         tx_nrzi <= next_tx_nrzi;
         mlt <= next_mlt;
         mlt3_pos_out <= next_pos;
         mlt3_neg_out <= next_neg;
      end
   end

   // ---------------- receive ----------------
   flc_pkg::flc_rx_e rx_st, next_rx_st;
   logic [9:0] win, next_win, nwin;
   logic [2:0] rx_cnt, next_rx_cnt;
   logic next_stb, next_dv, next_er;
   logic [3:0] next_rxd;
   logic [4:0] dec;
   logic bad;

   // mlt3 to nrzi: any non-zero level is nrzi high
   flc_cdr u_cdr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .nrzi_in(pos_s[1] | neg_s[1]),
      .bit_stb_out(cdr_stb),
      .nrz_out(cdr_nrz)
   );

   assign rx_scr.bit_en = cdr_stb;
   assign rx_scr.din = cdr_nrz;
   assign rx_scr.bypass = ~speed_100_in;
   assign rx_scr.sync = 1'b1;
   assign rx_scr.resync = bad;
   assign rx_lock_out = rx_scr.locked;

   flc_scrambler u_rx_scr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .s(rx_scr.scr)
   );

   // delimiter search, group alignment and decode
   always_comb begin
      nwin = {win[8:0], rx_scr.dout};
      dec = flc_pkg::flc_dec(nwin[`FLC_GRP_MSB:0]);
      next_win = win;
      next_rx_st = rx_st;
      next_rx_cnt = rx_cnt;
      next_stb = 1'b0;
      next_dv = rx_dv_out;
      next_er = rx_er_out;
      next_rxd = rxd_out;
      bad = 1'b0;
      if (cdr_stb) begin
         next_win = nwin;
         next_rx_cnt = (rx_cnt == `FLC_GRP_LAST) ? 3'h0 : rx_cnt + 1'b1;
         case (rx_st)
            flc_pkg::rx_idle: begin
               if (rx_scr.locked && nwin == `FLC_JK) begin
                  next_rx_st = flc_pkg::rx_frame;
                  next_rx_cnt = 3'h0;
                  next_stb = 1'b1;
                  next_dv = 1'b1;
                  next_er = 1'b0;
                  next_rxd = `FLC_PRE_NIB;
               end else if (rx_cnt == `FLC_GRP_LAST && rx_er_out) begin
                  next_stb = 1'b1;
                  next_er = 1'b0;
               end
            end
            flc_pkg::rx_frame: begin
               if (!rx_scr.locked) begin
                  next_rx_st = flc_pkg::rx_idle;
                  next_stb = 1'b1;
                  next_dv = 1'b0;
                  next_er = 1'b1;
               end else if (rx_cnt == `FLC_GRP_LAST) begin
                  next_stb = 1'b1;
                  if (dec[4]) begin
                     next_dv = 1'b1;
                     next_er = 1'b0;
                     next_rxd = dec[3:0];
                  end else if (nwin[`FLC_GRP_MSB:0] == `FLC_CG_T) begin
                     next_rx_st = flc_pkg::rx_idle;
                     next_dv = 1'b0;
                     next_er = 1'b0;
                  end else if (nwin[`FLC_GRP_MSB:0] == `FLC_CG_I) begin
                     next_rx_st = flc_pkg::rx_idle;
                     next_dv = 1'b0;
                     next_er = 1'b1;
                  end else begin
                     next_er = 1'b1;
                     bad = (nwin[`FLC_GRP_MSB:0] != `FLC_CG_H);
                  end
               end
            end
            default: next_rx_st = flc_pkg::rx_idle;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_st <= flc_pkg::rx_idle;
         win <= 10'h000;
         rx_cnt <= 3'h0;
         rx_stb_out <= 1'b0;
         rx_dv_out <= 1'b0;
         rx_er_out <= 1'b0;
         rxd_out <= 4'h0;
      end else begin
         rx_st <= next_rx_st;
         win <= next_win;
         rx_cnt <= next_rx_cnt;
         rx_stb_out <= next_stb;
         rx_dv_out <= next_dv;
         rx_er_out <= next_er;
         rxd_out <= next_rxd;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   mlt3_legal_a:
   assert property (!(mlt3_pos_out && mlt3_neg_out)) else $error("both line levels on");
   nrzi_mlt_a:
   assert property (tx_bit |=> (mlt != $past(mlt)) == (tx_nrzi != $past(tx_nrzi)))
      else $error("mlt3 step not tied to nrzi change");
   jk_start_a:
   assert property (boundary && tx_st == flc_pkg::tx_idle && tx_en_in
      |=> tx_sh == `FLC_CG_J && tx_st == flc_pkg::tx_k) else $error("frame not opened by J");
   t_end_a:
   assert property (boundary && tx_st == flc_pkg::tx_data && !tx_en_in
      |=> tx_sh == `FLC_CG_T && tx_st == flc_pkg::tx_r) else $error("frame not closed by T");
   bypass_bit_a:
   assert property (!speed_100_in && tx_bit
      |=> tx_nrzi == ($past(tx_nrzi) ^ $past(tx_sh[`FLC_GRP_MSB])))
      else $error("scrambler not bypassed");
   dv_lock_a:
   assert property ($rose(rx_dv_out) |-> $past(rx_scr.locked) && rxd_out == `FLC_PRE_NIB)
      else $error("data delivered before lock");
   rx_gap_a:
   assert property (rx_stb_out && rx_dv_out && !rx_er_out |=> !rx_stb_out [*8])
      else $error("rx nibbles too close");
   rx_stb_min_a:
   assert property (rx_stb_out |=> !rx_stb_out [*4]) else $error("rx strobes too close");
   rx_end_a:
   assert property (rx_stb_out && !rx_dv_out |-> rx_st == flc_pkg::rx_idle)
      else $error("dv low inside frame");

   tx_frame_c: cover property (tx_take_out && tx_st == flc_pkg::tx_data);
   rx_frame_c: cover property ($rose(rx_dv_out));
   rx_err_c: cover property ($rose(rx_er_out));
   rx_lock_c: cover property ($rose(rx_lock_out));
endmodule

// [bench/flc_mac_model.sv]
// mii mac model: sends queued {error, nibble} entries, records received nibbles
// assumes flc_line_coder on the same clock, take pulse sampled at rising edge
`timescale 1ns/1ps
module flc_mac_model (
   input wire logic clk_in,
   input wire logic take_in,
   input wire logic rx_stb_in,
   input wire logic rx_dv_in,
   input wire logic rx_er_in,
   input wire logic [3:0] rxd_in,
   output logic tx_en_out,
   output logic tx_er_out,
   output logic [3:0] txd_out
);
   logic [4:0] tx_q[$];
   logic [5:0] rx_q[$];
   logic [15:0] gap = 16'h0000;
   logic [15:0] last_gap = 16'h0000;

   // quiet mii at time zero
   initial begin
      tx_en_out = 1'b0;
      tx_er_out = 1'b0;
      txd_out = 4'h0;
   end

   // hold each nibble until taken, then present the next one
   always @(posedge clk_in) begin
      gap <= gap + 16'h0001;
      if (take_in && tx_en_out) begin
         void'(tx_q.pop_front());
         last_gap <= gap;
         gap <= 16'h0001;
      end
      if (tx_q.size() > 0) begin
         tx_en_out <= 1'b1;
         {tx_er_out, txd_out} <= tx_q[0];
      end else begin
         tx_en_out <= 1'b0;
      end
   end

   // record every receive strobe as {valid, error, nibble}
   always @(posedge clk_in) begin
      if (rx_stb_in) begin
         rx_q.push_back({rx_dv_in, rx_er_in, rxd_in});
      end
   end
endmodule

// [bench/flc_line_coder_test.sv]
// self-checking bench of the line coder, line output looped back to line input
// assumes the mac model beside it and a free-running 320 ns link clock
`timescale 1ns/1ps
module flc_line_coder_test;
   logic clk_in;
   logic rst_n_in;
   logic speed_100_in;
   logic tx_bit_clk_in;
   logic tx_en;
   logic tx_er;
   logic [3:0] txd;
   logic tx_take;
   logic pos;
   logic neg;
   logic rx_stb;
   logic rx_dv;
   logic rx_er;
   logic rx_lock;
   logic [3:0] rxd;
   logic [5:0] exp_q[$];
   int err_count = 0;
   int checks = 0;

   // system clock 25 MHz
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // link bit clock, phase unrelated to clk_in
   initial begin
      tx_bit_clk_in = 1'b0;
      #7;
      forever #160 tx_bit_clk_in = ~tx_bit_clk_in;
   end

   flc_line_coder u_dut (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .speed_100_in(speed_100_in),
      .tx_bit_clk_in(tx_bit_clk_in),
      .tx_en_in(tx_en),
      .tx_er_in(tx_er),
      .txd_in(txd),
      .tx_take_out(tx_take),
      .mlt3_pos_out(pos),
      .mlt3_neg_out(neg),
      .rx_pos_in(pos),
      .rx_neg_in(neg),
      .rx_stb_out(rx_stb),
      .rx_dv_out(rx_dv),
      .rx_er_out(rx_er),
      .rxd_out(rxd),
      .rx_lock_out(rx_lock)
   );

   flc_mac_model u_mac (
      .clk_in(clk_in),
      .take_in(tx_take),
      .rx_stb_in(rx_stb),
      .rx_dv_in(rx_dv),
      .rx_er_in(rx_er),
      .rxd_in(rxd),
      .tx_en_out(tx_en),
      .tx_er_out(tx_er),
      .txd_out(txd)
   );

   // compare one value, count it, report a mismatch
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // counts, verdict, end of run
   task automatic give_verdict();
      $display("counts: %0d checks, %0d mismatches", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // queue one mii entry away from the model's sampling edge
   task automatic send(input logic [4:0] ent);
      @(negedge clk_in);
      u_mac.tx_q.push_back(ent);
   endtask

   // reset held 13 cycles, outputs judged while held
   task automatic do_reset(input string name);
      logic [7:0] seen;
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      seen = {2'b00, pos, neg, rx_stb, rx_dv, rx_er, rx_lock};
      check(name, seen, {7'h00, ~speed_100_in});
      u_mac.tx_q.delete();
      u_mac.rx_q.delete();
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      $display("test %s done", name);
   endtask

   // wait for all expected strobes, then judge them and the take spacing
   task automatic collect(input string name);
      int n = 0;
      logic [5:0] got;
      logic [5:0] mask;
      while (u_mac.rx_q.size() < exp_q.size() && n < 6000) begin
         @(posedge clk_in);
         n++;
      end
      if (n == 6000) begin
         err_count++;
         give_verdict();
      end
      repeat (200) @(posedge clk_in);
      check({name, " count"}, 8'(u_mac.rx_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) begin
         got = (i < u_mac.rx_q.size()) ? u_mac.rx_q[i] : 6'h00;
         mask = (exp_q[i][5:4] == 2'b00) ? 6'h30 : 6'h3F;
         check(name, {2'b00, got & mask}, {2'b00, exp_q[i]});
      end
      check({name, " take gap"}, u_mac.last_gap[7:0], 8'h28);
      exp_q.delete();
      u_mac.rx_q.delete();
      $display("test %s done", name);
   endtask

   // count line level changes, a forbidden both-high level spoils the count
   task automatic count_steps(input int cycles, output int steps);
      logic [1:0] prev;
      steps = 0;
      @(negedge clk_in);
      prev = {pos, neg};
      repeat (cycles) begin
         @(negedge clk_in);
         if ({pos, neg} !== prev) steps++;
         if (pos === 1'b1 && neg === 1'b1) steps = 999;
         prev = {pos, neg};
      end
   endtask

   // descrambler locks on looped-back idle within a bounded time
   task automatic test_lock();
      int n = 0;
      while (rx_lock !== 1'b1 && n < 4000) begin
         @(negedge clk_in);
         n++;
      end
      if (n == 4000) begin
         err_count++;
         give_verdict();
      end
      check("lock", {7'h00, rx_lock}, 8'h01);
      $display("test lock done");
   endtask

   // scrambled idle must not toggle on every bit
   task automatic test_scrambled_idle();
      int steps;
      count_steps(192, steps);
      check("scrambled idle", {7'h00, steps > 0 && steps < 24}, 8'h01);
      $display("test scrambled idle done");
   endtask

   // every nibble value through the full path, J and K first
   task automatic test_all_codes();
      send(5'h05);
      send(5'h05);
      exp_q.push_back(6'h25);
      for (int i = 0; i < 16; i++) begin
         send({1'b0, 4'(i)});
         exp_q.push_back({2'b10, 4'(i)});
      end
      exp_q.push_back(6'h00);
      collect("all codes");
   endtask

   // error group mid-frame flagged, nibble held
   task automatic test_tx_error();
      send(5'h05);
      send(5'h05);
      send(5'h0A);
      send(5'h10);
      send(5'h0B);
      exp_q = '{6'h25, 6'h2A, 6'h3A, 6'h2B, 6'h00};
      collect("tx error");
   endtask

   // second frame requested while the first one is still closing
   task automatic test_back_to_back();
      int n = 0;
      send(5'h05);
      send(5'h05);
      send(5'h03);
      while ((u_mac.tx_q.size() > 0 || tx_en !== 1'b0) && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      if (n == 2000) begin
         err_count++;
         give_verdict();
      end
      // let the T group start, so the new request lands during T or R
      repeat (48) @(posedge clk_in);
      send(5'h05);
      send(5'h05);
      send(5'h0C);
      exp_q = '{6'h25, 6'h23, 6'h00, 6'h25, 6'h2C, 6'h00};
      collect("back to back");
   endtask

   // low speed: no scrambling, idle toggles every bit, frames still pass
   task automatic test_bypass();
      int steps;
      @(posedge clk_in);
      speed_100_in <= 1'b0;
      @(negedge clk_in);
      check("bypass lock", {7'h00, rx_lock}, 8'h01);
      repeat (300) @(posedge clk_in);
      u_mac.rx_q.delete();
      count_steps(80, steps);
      check("bypass idle", 8'(steps), 8'h0A);
      send(5'h05);
      send(5'h05);
      send(5'h07);
      send(5'h0E);
      exp_q = '{6'h25, 6'h27, 6'h2E, 6'h00};
      collect("bypass frame");
   endtask

   // reset again in mid-frame at full speed
   task automatic test_mid_reset();
      @(posedge clk_in);
      speed_100_in <= 1'b1;
      send(5'h05);
      send(5'h05);
      send(5'h09);
      repeat (60) @(posedge clk_in);
      do_reset("mid reset");
   endtask

   // main sequence
   initial begin
      rst_n_in = 1'b0;
      speed_100_in = 1'b1;
      do_reset("power-on reset");
      test_lock();
      test_scrambled_idle();
      test_all_codes();
      test_tx_error();
      test_back_to_back();
      test_bypass();
      test_mid_reset();
      test_lock();
      give_verdict();
   end

   // hang guard
   initial begin
      #4000000;
      err_count++;
      give_verdict();
   end
endmodule
